/* include/dmsd_regs.vh */
// Purpose: Constants for the dual-mode switch debouncer.
// Assumes: 125 MHz system clock, millisecond sampling tick.
// Notes: Definitions only.
`ifndef DMSD_REGS_VH
`define DMSD_REGS_VH

// ==========================================================
// Timing
`define DMSD_CLK_HZ 125000000
`define DMSD_TICK_NS 1000000
`define DMSD_CLK_NS 8
`define DMSD_TICK_CYC (`DMSD_TICK_NS / `DMSD_CLK_NS)
`define DMSD_STABLE_MS 10
`define DMSD_HOLD_MS 1000
`define DMSD_FILT_LEN 20

// ==========================================================
// Modes and states
`define DMSD_MODE_FILT 1'b0
`define DMSD_MODE_BRUTE 1'b1
`define DMSD_BS_IDLE 1'b0
`define DMSD_BS_WAIT 1'b1

`endif

/* rtl/dmsd_sync.v */
// Purpose: Three-flop input synchroniser with agreement check.
// Assumes: Input is asynchronous to clk_sys_i.
// Notes: First flop feeds only the second flop.
`timescale 1ns/100ps
module dmsd_sync (
   // Clock and reset
   input wire clk_sys_i,
   input wire sys_rst_i,
   // Raw and clean level
   input wire async_i,
   output reg level_o
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;

   // ==========================================================
   // Synchroniser chain; change counts once stages two and three agree
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         level_o <= 1'b0;
      end else begin
         s1_ff <= async_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            level_o <= s3_ff;
         end
      end
   end
endmodule // dmsd_sync

/* rtl/dmsd_tick.v */
// Purpose: Divider producing a one-cycle millisecond tick.
// Assumes: TICK_CYC system clocks per tick.
// Notes: Shorten TICK_CYC in simulation.
`timescale 1ns/100ps
module dmsd_tick #(
   parameter TICK_CYC = 125000
) (
   // Clock and reset
   input wire clk_sys_i,
   input wire sys_rst_i,
   // Tick out
   output reg tick_o
);
   reg [16:0] cnt_ff;

   // ==========================================================
   // Free-running divider
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         cnt_ff <= 17'h00000;
         tick_o <= 1'b0;
      end else if (cnt_ff == TICK_CYC[16:0] - 17'h00001) begin
         cnt_ff <= 17'h00000;
         tick_o <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 17'h00001;
         tick_o <= 1'b0;
      end
   end
endmodule // dmsd_tick

/* rtl/dmsd_top.v */
// Purpose: Dual-mode push-button debouncer driving two indicator LEDs.
// Assumes: Button active high (pressed = 1), single 125 MHz clock.
// Notes: Filter mode after reset; 1 s hold swaps methods.
// Operation
// - A brute-force release counts as settled only after being unchanged over 10 ms.
// - Brute-force fires once on leaving release, then waits for release.
// - After a brute press, a stable 10 ms release re-arms detection.
// - Any non-released sample in the wait restarts the 10 ms timer.
// - The filter counter counts up when closed and down when open.
// - The filter counter saturates at both limits.
// - A filtered action fires only on the first saturating sample.
// - A state is not re-reported until the opposite limit is reached.
// - The filter length is a parameter.
// - Each brute-force press toggles the first LED.
// - In filter mode LED2 shows pressed and LED1 shows released.
// - The block leaves reset in filter mode.
// - A hold over 1 s in filter mode selects brute-force, LED1 on.
// - A hold over 1 s in brute-force mode selects filter, LED2 on.
`timescale 1ns/100ps
`include "dmsd_regs.vh"
module dmsd_top #(
   parameter TICK_CYC = `DMSD_TICK_CYC,
   parameter STABLE_MS = `DMSD_STABLE_MS,
   parameter HOLD_MS = `DMSD_HOLD_MS,
   parameter FILT_LEN = `DMSD_FILT_LEN
) (
   // Clock and reset
   input wire clk_sys_i,
   input wire sys_rst_i,
   // Button
   input wire push_button_input_i,
   // Indicators
   output reg first_indicator_led_o,
   output reg second_indicator_led_o,
   output reg brute_mode_o,
   output reg press_evt_o
);
   wire btn;
   wire tick;
   reg mode_ff;
   reg nxt_mode;
   reg bstate_ff;
   reg nxt_bstate;
   reg [10:0] stab_ff;
   reg [10:0] nxt_stab;
   reg [10:0] hold_ff;
   reg [10:0] nxt_hold;
   reg hold_done_ff;
   reg nxt_hold_done;
   reg [7:0] filt_ff;
   reg [7:0] nxt_filt;
   reg fstate_ff;
   reg nxt_fstate;
   reg led1;
   reg led2;
   reg pevt;

   // ==========================================================
   // Input synchroniser and millisecond tick
   dmsd_sync u_sync (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .async_i(push_button_input_i),
      .level_o(btn)
   );

   dmsd_tick #(.TICK_CYC(TICK_CYC)) u_tick (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .tick_o(tick)
   );

   // ==========================================================
   // Next-state logic, evaluated only on a tick
   always @* begin
      nxt_mode = mode_ff;
      nxt_bstate = bstate_ff;
      nxt_stab = stab_ff;
      nxt_hold = hold_ff;
      nxt_hold_done = hold_done_ff;
      nxt_filt = filt_ff;
      nxt_fstate = fstate_ff;
      led1 = first_indicator_led_o;
      led2 = second_indicator_led_o;
      pevt = 1'b0;
      if (tick) begin
         // Hold timer; one swap per hold, re-armed by release
         if (!btn) begin
            nxt_hold = 11'h000;
            nxt_hold_done = 1'b0;
         end else if (!hold_done_ff) begin
            if (hold_ff >= HOLD_MS[10:0]) begin
               nxt_hold_done = 1'b1;
               nxt_hold = 11'h000;
               if (mode_ff == `DMSD_MODE_FILT) begin
                  nxt_mode = `DMSD_MODE_BRUTE;
                  led1 = 1'b1;
                  led2 = 1'b0;
                  nxt_bstate = `DMSD_BS_WAIT;
                  nxt_stab = 11'h000;
               end else begin
                  nxt_mode = `DMSD_MODE_FILT;
                  led1 = 1'b0;
                  led2 = 1'b1;
                  nxt_filt = FILT_LEN[7:0];
                  nxt_fstate = 1'b1;
               end
            end else begin
               nxt_hold = hold_ff + 11'h001;
            end
         end
         if (nxt_mode == mode_ff) begin
            if (mode_ff == `DMSD_MODE_BRUTE) begin
               case (bstate_ff)
                  `DMSD_BS_IDLE: begin
                     if (btn) begin
                        led1 = ~first_indicator_led_o;
                        pevt = 1'b1;
                        nxt_bstate = `DMSD_BS_WAIT;
                        nxt_stab = 11'h000;
                     end
                  end
                  `DMSD_BS_WAIT: begin
                     if (btn) begin
                        nxt_stab = 11'h000;
                     end else if (stab_ff >= STABLE_MS[10:0]) begin
                        nxt_bstate = `DMSD_BS_IDLE;
                     end else begin
                        nxt_stab = stab_ff + 11'h001;
                     end
                  end
                  default: nxt_bstate = `DMSD_BS_IDLE;
               endcase
            end else begin
               // Saturating up/down filter
               if (btn && filt_ff != FILT_LEN[7:0]) begin
                  nxt_filt = filt_ff + 8'h01;
               end else if (!btn && filt_ff != 8'h00) begin
                  nxt_filt = filt_ff - 8'h01;
               end
               if (nxt_filt == FILT_LEN[7:0] && !fstate_ff) begin
                  nxt_fstate = 1'b1;
                  pevt = 1'b1;
               end else if (nxt_filt == 8'h00 && fstate_ff) begin
                  nxt_fstate = 1'b0;
                  pevt = 1'b1;
               end
               if (pevt) begin
                  led2 = nxt_fstate;
                  led1 = ~nxt_fstate;
               end
            end
         end
      end
   end

   // ==========================================================
   // State registers; reset starts in filter mode, released
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         mode_ff <= `DMSD_MODE_FILT;
         bstate_ff <= `DMSD_BS_IDLE;
         stab_ff <= 11'h000;
         hold_ff <= 11'h000;
         hold_done_ff <= 1'b0;
         filt_ff <= 8'h00;
         fstate_ff <= 1'b0;
         first_indicator_led_o <= 1'b0;
         second_indicator_led_o <= 1'b0;
         brute_mode_o <= 1'b0;
         press_evt_o <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         bstate_ff <= nxt_bstate;
         stab_ff <= nxt_stab;
         hold_ff <= nxt_hold;
         hold_done_ff <= nxt_hold_done;
         filt_ff <= nxt_filt;
         fstate_ff <= nxt_fstate;
         first_indicator_led_o <= led1;
         second_indicator_led_o <= led2;
         brute_mode_o <= nxt_mode;
         press_evt_o <= pevt;
      end
   end
endmodule // dmsd_top

/* tb/dmsd_props.sv */
// Purpose: Port assertions for dmsd_top.
// Assumes: Synchronous active-high reset.
// Notes: Bound after endmodule.
`timescale 1ns/100ps
module dmsd_props (
   // Clock, reset and button
   input wire clk_sys_i,
   input wire sys_rst_i,
   input wire push_button_input_i,
   // Indicators and status
   input wire first_indicator_led_o,
   input wire second_indicator_led_o,
   input wire brute_mode_o,
   input wire press_evt_o
);
   wire l1 = first_indicator_led_o;
   wire l2 = second_indicator_led_o;
   wire bm = brute_mode_o;
   wire ev = press_evt_o;
   // ============
   // Past-reset guards stop a short reset pulse tripping edges
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   chk_reset_clears: assert property (disable iff (1'b0)
      sys_rst_i |=> !(l1 || l2 || bm || ev)) else $error("reset");
   chk_evt_alone: assert property (ev |=> !ev [*8])
      else $error("event width");
   chk_brute_leds: assert property ($rose(bm) |-> l1 && !l2)
      else $error("brute LEDs");
   chk_filt_leds: assert property (
      !$past(sys_rst_i) && $fell(bm) |-> l2 && !l1) else $error("filter LEDs");
   chk_led_excl: assert property (!bm |-> !(l1 && l2))
      else $error("both LEDs");
   chk_brute_toggle: assert property (
      bm && $past(bm) && ev |-> l1 != $past(l1)) else $error("no toggle");
   chk_led_cause: assert property (
      !$past(sys_rst_i) && $changed({l1, l2}) |-> ev || $changed(bm))
      else $error("LED without event");
   chk_swap_held: assert property (
      !$past(sys_rst_i) && $changed(bm) |-> $past(push_button_input_i, 8))
      else $error("swap unheld");
   cover property ($rose(bm));
   cover property ($fell(bm));
   cover property (!bm && ev && l2);
endmodule // dmsd_props
bind dmsd_top dmsd_props u_props (.clk_sys_i(clk_sys_i),
   .sys_rst_i(sys_rst_i), .push_button_input_i(push_button_input_i),
   .first_indicator_led_o(first_indicator_led_o),
   .second_indicator_led_o(second_indicator_led_o),
   .brute_mode_o(brute_mode_o), .press_evt_o(press_evt_o));

/* tb/dmsd_btn_model.sv */
// Purpose: Push-button contact that chatters.
// Assumes: Chatter lasts bounce_i clocks.
// Notes: Settles on the intended level.
`timescale 1ns/100ps
module dmsd_btn_model (
   // Clock and intended level
   input wire clk_sys_i,
   input wire level_i,
   input wire [7:0] bounce_i,
   // Contact
   output wire contact_o
);
   reg last_ff = 1'b0;
   reg [7:0] cnt_ff = 8'h00;
   // ============
   // Every change restarts chatter, kept far below 10 ms
   always @(posedge clk_sys_i) begin
      if (level_i != last_ff) begin
         last_ff <= level_i;
         cnt_ff <= bounce_i;
      end else if (cnt_ff != 8'h00) begin
         cnt_ff <= cnt_ff - 8'h01;
      end
   end
   assign contact_o = (cnt_ff != 8'h00) ? cnt_ff[1] : last_ff;
endmodule // dmsd_btn_model

/* tb/tb_dual_mode_switch_debouncer.sv */
// Purpose: Self-checking bench for dmsd_top.
// Assumes: Shortened tick, hold and filter.
// Notes: Inputs move on the falling edge.
`timescale 1ns/100ps
module tb_dual_mode_switch_debouncer;
   localparam TK = 10;
   localparam HOLD = 20;
   localparam FL = 4;
   reg clk_sys_i = 1'b0;
   reg sys_rst_i = 1'b1;
   reg lvl = 1'b0;
   wire btn, l1, l2, bm, ev;
   integer fails = 0, checks = 0, evts = 0, e0 = 0;
   // ============
   // Clock, event tally, button and DUT
   always #4 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (ev === 1'b1) evts <= evts + 1;
   dmsd_btn_model u_btn (.clk_sys_i(clk_sys_i), .level_i(lvl),
      .bounce_i(8'h1E), .contact_o(btn));
   dmsd_top #(.TICK_CYC(TK), .HOLD_MS(HOLD), .FILT_LEN(FL)) DUT (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .push_button_input_i(btn), .first_indicator_led_o(l1),
      .second_indicator_led_o(l2), .brute_mode_o(bm), .press_evt_o(ev));
   // ============
   // Shared tasks
   task check(input [1:0] seen, input [1:0] exp);
      checks = checks + 1;
      if (seen !== exp) $display("MISMATCH %0t got %b", $time, seen);
      fails = fails + (seen !== exp);
   endtask
   task drive(input v, input integer n);
      lvl = v;
      repeat (n * TK) @(negedge clk_sys_i);
   endtask
   // Bounded wait that returns as soon as an event lands
   task wait_evt(input integer n);
      e0 = evts;
      repeat (n * TK) if (evts == e0) @(negedge clk_sys_i);
   endtask
   task complete_run;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ============
   // Scenarios
   task t_filter;
      drive(1'b1, 2);
      drive(1'b0, 6);
      check(2'(evts), 2'h0);
      drive(1'b1, 0);
      wait_evt(FL + 8);
      check({l1, l2}, 2'h1);
      drive(1'b1, 6);
      check(2'(evts - e0), 2'h1);
      drive(1'b0, 0);
      wait_evt(FL + 8);
      check({l1, l2}, 2'h2);
      $display("filter done");
   endtask
   task t_swap;
      drive(1'b1, HOLD - 2);
      check({bm, l2}, 2'h1);
      drive(1'b1, 8);
      check({bm, l1}, 2'h3);
      check({l2, bm}, 2'h1);
      drive(1'b0, 16);
      $display("swap done");
   endtask
   // Presses in the release wait must stay dead
   task t_brute;
      drive(1'b1, 0);
      wait_evt(4);
      check({l1, l2}, 2'h0);
      drive(1'b1, 5);
      drive(1'b0, 9);
      drive(1'b1, 5);
      drive(1'b0, 9);
      drive(1'b1, 4);
      check(2'(evts - e0), 2'h1);
      drive(1'b0, 16);
      drive(1'b1, 0);
      wait_evt(4);
      check({l1, l2}, 2'h2);
      $display("brute done");
   endtask
   task t_back;
      drive(1'b1, HOLD + 4);
      check({bm, l1}, 2'h0);
      check({l2, bm}, 2'h2);
      drive(1'b0, FL + 8);
      check({l1, l2}, 2'h2);
      $display("back done");
   endtask
   initial begin
      repeat (5) @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      check({l1, l2}, 2'h0);
      check({bm, ev}, 2'h0);
      t_filter;
      t_swap;
      t_brute;
      t_back;
      complete_run;
   end
   // Watchdog, about twelve times the expected run
   initial begin
      #160000;
      fails = fails + 1;
      complete_run;
   end
endmodule // tb_dual_mode_switch_debouncer
